/* pkg/ddc_pkg.sv */
package ddc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths of the pin group and of the captured word, FIFO depth and synchroniser length.
    localparam int DQ_W       = 36;
    localparam int WORD_W     = 2 * DQ_W;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_LEN   = 3;

    ////////////////////////////////////////////////////////////////////////
    // Strobe delay reference.
    localparam int DQS_RIGHT  = 10;
    localparam int DQS_LEFT   = 8;
    localparam int DQS_PAIRS  = DQS_RIGHT + DQS_LEFT;
    localparam int CODE_W     = 8;
    localparam int LANE_BITS  = DQS_PAIRS * CODE_W;
    // A quarter of the measured period gives a 90 degree strobe shift.
    localparam int PHASE_SHIFT = 2;
    localparam logic [CODE_W-1:0] PERIOD_MAX  = 8'hff;
    localparam logic [CODE_W-1:0] PERIOD_STEP = 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Reset level of the cell data registers.
    localparam logic PWRUP_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        DDC_IN    = 2'b00,
        DDC_OUT   = 2'b01,
        DDC_BIDIR = 2'b10
    } ddc_mode_t;

    typedef enum logic [1:0] {
        DDC_X4  = 2'b00,
        DDC_X9  = 2'b01,
        DDC_X18 = 2'b10,
        DDC_X36 = 2'b11
    } ddc_grp_t;

    localparam logic [DQ_W-1:0] MASK_X4  = 36'h0_0000_000f;
    localparam logic [DQ_W-1:0] MASK_X9  = 36'h0_0000_01ff;
    localparam logic [DQ_W-1:0] MASK_X18 = 36'h0_0003_ffff;
    localparam logic [DQ_W-1:0] MASK_X36 = 36'hf_ffff_ffff;

    function automatic logic [DQ_W-1:0] ddc_lane_mask(input ddc_grp_t g);
        case (g)
            DDC_X4:  return MASK_X4;
            DDC_X9:  return MASK_X9;
            DDC_X18: return MASK_X18;
            default: return MASK_X36;
        endcase
    endfunction

endpackage

/* verilog/ddc_fifo.sv */
`timescale 1ns/1ps
module ddc_fifo
    import ddc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    output logic                  o_valid,
    output logic [WIDTH-1:0]      o_data,
    input  wire logic             i_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] STEP = AW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire logic        push = i_valid & o_ready;
    wire logic        pop  = (count != '0) & (~o_valid | i_ready);
    wire logic [AW:0] next_count = count + {{AW{1'b0}}, push}
                                         - {{AW{1'b0}}, pop};

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count   <= '0;
            o_ready <= 1'b1;
        end else begin
            wr_ptr  <= push ? wr_ptr + STEP : wr_ptr;
            rd_ptr  <= pop ? rd_ptr + STEP : rd_ptr;
            count   <= next_count;
            o_ready <= next_count < FULL;
        end
    end

    // The head is moved into a register so the reader sees a flop.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid <= 1'b0;
            o_data  <= '0;
        end else if (pop) begin
            o_valid <= 1'b1;
            o_data  <= mem[rd_ptr];
        end else if (i_ready) begin
            o_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    property p_full_stall;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (count == FULL) |-> !o_ready;
    endproperty
    a_full_stall: assert property (p_full_stall) // R11
        else $error("FIFO full but ready high.");

    property p_head_hold;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_valid && !i_ready) |=> (o_valid && $stable(o_data));
    endproperty
    a_head_hold: assert property (p_head_hold) // R11
        else $error("FIFO head changed while stalled.");

endmodule

/* verilog/ddc_phase_ref.sv */
`timescale 1ns/1ps
module ddc_phase_ref
    import ddc_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_ref_pin,
    input  wire logic                 i_ref_pll,
    input  wire logic                 i_use_pll,
    input  wire logic [DQS_PAIRS-1:0] i_lane_en,
    output logic [LANE_BITS-1:0]      o_lane_code,
    output logic                      o_locked
);

    logic [SYNC_LEN-1:0] ref_sync;
    logic                ref_lvl;
    logic [CODE_W-1:0]   period;
    logic [CODE_W-1:0]   code;

    // Source is muxed before the synchroniser; it is a static choice.
    wire logic ref_raw   = i_use_pll ? i_ref_pll : i_ref_pin;
    wire logic ref_agree = ref_sync[1] == ref_sync[2];
    wire logic ref_rise  = ref_agree & ref_sync[2] & ~ref_lvl;
    wire logic per_full  = period == PERIOD_MAX;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_sync <= '0;
            ref_lvl  <= 1'b0;
        end else begin
            ref_sync <= {ref_sync[SYNC_LEN-2:0], ref_raw};
            ref_lvl  <= ref_agree ? ref_sync[2] : ref_lvl;
        end
    end

    // R10 period to delay
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            period   <= '0;
            code     <= '0;
            o_locked <= 1'b0;
        end else if (ref_rise) begin
            period   <= PERIOD_STEP;
            code     <= period >> PHASE_SHIFT;
            o_locked <= ~per_full;
        end else if (per_full) begin
            o_locked <= 1'b0;
        end else begin
            period   <= period + PERIOD_STEP;
        end
    end

    // R15 lane fan-out
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_lane_code <= '0;
        end else begin
            for (int i = 0; i < DQS_PAIRS; i++) begin
                o_lane_code[i*CODE_W +: CODE_W] <= i_lane_en[i] ? code : '0;
            end
        end
    end

    property p_lane_off;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !i_lane_en[0] |=> (o_lane_code[CODE_W-1:0] == '0);
    endproperty
    a_lane_off: assert property (p_lane_off) // R15
        else $error("Disabled strobe lane still carries a code.");

    property p_quarter;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        ref_rise |=> (code == ($past(period) >> PHASE_SHIFT));
    endproperty
    a_quarter: assert property (p_quarter) // R10
        else $error("Delay code is not a quarter of the period.");

endmodule

/* verilog/ddc_dq_cell.sv */
`timescale 1ns/1ps
// Behaviour
// R1 - Each cell holds six storage registers clocking data on both edges.
// R2 - Cell works as DDR input, DDR output or bidirectional DDR.
// R3 - Two capture registers sample on alternate strobe edges.
// R4 - Rising sample is held so both bits align to one selectable edge.
// R5 - Every input into the cell may be inverted at the cell; the code inverts only the data, transmit data, output enable and strobe inputs.
// R6 - Pin driver enables low; the user enable passes an inverter.
// R7 - Bidirectional use combines input and output paths of one cell.
// R8 - Enable register changes only on the falling clock edge.
// R9 - Strobe groups of 4, 9, 18 or 36 data bits.
// R10 - A compensated delay aligns the strobe with its data window.
// R11 - The delayed strobe clocks the data capture registers of its group.
// R12 - Separate top and bottom reference circuits set their edge delays.
// R13 - Reference clock must match the strobe frequency.
// R14 - Reference from pin or PLL; PLL 5 top, PLL 6 bottom only.
// R15 - Up to 18 strobe pairs per edge, 10 right and 8 left.
// R16 - Output and enable registers share one clock; input has its own.
// R17 - Registers power up at a fixed level with clear and sync reset; capture, toggle-sync, FIFO and delay-reference flops take only the clear.
// R18 - Output registers are multiplexed onto the pin by clock phase.
module ddc_dq_cell
    import ddc_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_sclr,
    input  wire ddc_mode_t            i_mode,
    input  wire ddc_grp_t             i_grp_w,
    input  wire logic                 i_align_rise,
    input  wire logic                 i_inv_dq,
    input  wire logic                 i_inv_dqs,
    input  wire logic                 i_inv_tx,
    input  wire logic                 i_inv_oe,
    input  wire logic                 i_dqs,
    input  wire logic [DQ_W-1:0]      i_dq,
    output logic [DQ_W-1:0]           o_dq,
    output logic [DQ_W-1:0]           o_dq_oe,
    output logic                      o_mem_clk,
    input  wire logic                 i_tx_valid,
    input  wire logic [DQ_W-1:0]      i_tx_a,
    input  wire logic [DQ_W-1:0]      i_tx_b,
    input  wire logic                 i_tx_oe,
    output logic                      o_tx_ready,
    output logic                      o_rx_valid,
    output logic [WORD_W-1:0]         o_rx_data,
    input  wire logic                 i_rx_ready,
    output logic                      o_cap_ready,
    output logic                      o_rx_overflow,
    input  wire logic                 i_ovf_clr,
    input  wire logic                 i_top_ref_pin,
    input  wire logic                 i_top_pll5_clk,
    input  wire logic                 i_top_use_pll,
    input  wire logic [DQS_PAIRS-1:0] i_top_dqs_en,
    output logic [LANE_BITS-1:0]      o_top_dqs_code,
    output logic                      o_top_locked,
    input  wire logic                 i_bot_ref_pin,
    input  wire logic                 i_bot_pll6_clk,
    input  wire logic                 i_bot_use_pll,
    input  wire logic [DQS_PAIRS-1:0] i_bot_dqs_en,
    output logic [LANE_BITS-1:0]      o_bot_dqs_code,
    output logic                      o_bot_locked
);

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and input inversion.

    // R1 six cell registers
    logic [DQ_W-1:0] out_a;
    logic [DQ_W-1:0] out_b;
    logic            drv_en_n;

    // R2 mode decode
    wire logic mode_tx = (i_mode == DDC_OUT) || (i_mode == DDC_BIDIR);
    // R7 both paths
    wire logic mode_rx = (i_mode == DDC_IN) || (i_mode == DDC_BIDIR);

    // R5 input inversion
    wire logic [DQ_W-1:0] tx_a_eff = i_tx_a ^ {DQ_W{i_inv_tx}};
    wire logic [DQ_W-1:0] tx_b_eff = i_tx_b ^ {DQ_W{i_inv_tx}};
    wire logic            oe_req   = i_tx_oe ^ i_inv_oe;

    wire logic oe_eff = (i_mode == DDC_OUT)
                      | ((i_mode == DDC_BIDIR) & oe_req);
    wire logic take   = o_tx_ready & i_tx_valid;

    ////////////////////////////////////////////////////////////////////////
    // Output path, all on the system clock.

    // R18 phase select
    wire logic [DQ_W-1:0] next_dq = o_mem_clk ? out_b : out_a;
    // R8 falling edge only
    wire logic next_drv_en_n = o_mem_clk ? ~oe_eff : drv_en_n;

    // R16 shared clock
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mem_clk  <= 1'b0;
            o_tx_ready <= 1'b0;
        end else if (i_sclr) begin
            o_mem_clk  <= 1'b0;
            o_tx_ready <= 1'b0;
        end else begin
            o_mem_clk  <= ~o_mem_clk;
            o_tx_ready <= ~o_mem_clk & mode_tx;
        end
    end

    // R17 power-up level
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_a <= {DQ_W{PWRUP_LEVEL}};
            out_b <= {DQ_W{PWRUP_LEVEL}};
        end else if (i_sclr) begin
            out_a <= {DQ_W{PWRUP_LEVEL}};
            out_b <= {DQ_W{PWRUP_LEVEL}};
        end else if (take) begin
            out_a <= tx_a_eff;
            out_b <= tx_b_eff;
        end
    end

    // R18 pin mux
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dq <= {DQ_W{PWRUP_LEVEL}};
        end else if (i_sclr) begin
            o_dq <= {DQ_W{PWRUP_LEVEL}};
        end else begin
            o_dq <= next_dq;
        end
    end

    // R6 active-low driver
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            drv_en_n <= 1'b1;
            o_dq_oe  <= '0;
        end else if (i_sclr) begin
            drv_en_n <= 1'b1;
            o_dq_oe  <= '0;
        end else begin
            drv_en_n <= next_drv_en_n;
            o_dq_oe  <= {DQ_W{~next_drv_en_n}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture on the delayed strobe; this logic runs only while it toggles.

    logic [DQ_W-1:0]   rise_q;
    logic [DQ_W-1:0]   fall_q;
    logic [WORD_W-1:0] pr_word;
    logic [WORD_W-1:0] nf_word;
    logic              pr_tog;
    logic              nf_tog;

    // R3 rising sample
    // R11 strobe clocks data
    always_ff @(posedge i_dqs or negedge i_rstn) begin
        if (!i_rstn) begin
            rise_q  <= '0;
            pr_word <= '0;
            pr_tog  <= 1'b0;
        end else begin
            rise_q  <= i_dq;
            pr_word <= {i_dq, fall_q};
            pr_tog  <= ~pr_tog;
        end
    end

    // R3 falling sample
    // R4 held rising bit
    always_ff @(negedge i_dqs or negedge i_rstn) begin
        if (!i_rstn) begin
            fall_q  <= '0;
            nf_word <= '0;
            nf_tog  <= 1'b0;
        end else begin
            fall_q  <= i_dq;
            nf_word <= {i_dq, rise_q};
            nf_tog  <= ~nf_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Toggle crossing into the system clock.

    logic [SYNC_LEN-1:0] tog_sync;
    logic                tog_seen;

    // R4 edge select
    wire logic align_sel = i_align_rise ^ i_inv_dqs;
    wire logic tog_sel   = align_sel ? pr_tog : nf_tog;
    wire logic [WORD_W-1:0] word_sel = align_sel ? pr_word : nf_word;

    wire logic tog_agree = tog_sync[1] == tog_sync[2];
    wire logic cap_ev    = tog_agree & (tog_sync[2] != tog_seen);

    // R5 strobe inversion
    wire logic [WORD_W-1:0] word_ord = i_inv_dqs
        ? {word_sel[DQ_W-1:0], word_sel[WORD_W-1:DQ_W]} : word_sel;

    // R9 group width
    wire logic [DQ_W-1:0]   lane_mask = ddc_lane_mask(i_grp_w);
    // R5 data inversion
    wire logic [WORD_W-1:0] rx_word =
        (word_ord ^ {WORD_W{i_inv_dq}}) & {lane_mask, lane_mask};

    // R2 input path gate
    wire logic cap_push = cap_ev & mode_rx;
    wire logic next_ovf = (cap_push & ~o_cap_ready)
                        | (o_rx_overflow & ~i_ovf_clr);

    // The word is held for a whole strobe period, far longer than the
    // three system cycles the toggle needs, so it is stable when sampled.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_sync <= '0;
            tog_seen <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[SYNC_LEN-2:0], tog_sel};
            tog_seen <= tog_agree ? tog_sync[2] : tog_seen;
        end
    end

    // A lost word sets the flag; a new loss beats a clear.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_overflow <= 1'b0;
        end else if (i_sclr) begin
            o_rx_overflow <= 1'b0;
        end else begin
            o_rx_overflow <= next_ovf;
        end
    end

    ddc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_valid   (cap_push),
        .i_data    (rx_word),
        .o_ready   (o_cap_ready),
        .o_valid   (o_rx_valid),
        .o_data    (o_rx_data),
        .i_ready   (i_rx_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Delay references, one for the top and one for the bottom edge of the die.

    // R12 top reference
    // R14 top PLL only
    ddc_phase_ref u_top_ref (
        .i_sys_clk   (i_sys_clk),
        .i_rstn      (i_rstn),
        .i_ref_pin   (i_top_ref_pin),
        .i_ref_pll   (i_top_pll5_clk),
        .i_use_pll   (i_top_use_pll),
        .i_lane_en   (i_top_dqs_en),
        .o_lane_code (o_top_dqs_code),
        .o_locked    (o_top_locked)
    );

    // R12 bottom reference
    // R14 bottom PLL only
    ddc_phase_ref u_bot_ref (
        .i_sys_clk   (i_sys_clk),
        .i_rstn      (i_rstn),
        .i_ref_pin   (i_bot_ref_pin),
        .i_ref_pll   (i_bot_pll6_clk),
        .i_use_pll   (i_bot_use_pll),
        .i_lane_en   (i_bot_dqs_en),
        .o_lane_code (o_bot_dqs_code),
        .o_locked    (o_bot_locked)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_tx_ddr;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        take |-> ##2 (o_mem_clk && o_dq == $past(tx_a_eff, 2))
                 ##1 (!o_mem_clk && o_dq == $past(tx_b_eff, 3));
    endproperty
    a_tx_ddr: assert property (p_tx_ddr) // R18
        else $error("DDR output bits not in their clock phases.");

    property p_oe_fall;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        $changed(o_dq_oe[0]) |-> $fell(o_mem_clk);
    endproperty
    a_oe_fall: assert property (p_oe_fall) // R8
        else $error("Output enable moved off the falling edge.");

    property p_oe_low;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        (o_mem_clk && oe_eff) |=> (!drv_en_n && o_dq_oe[0]);
    endproperty
    a_oe_low: assert property (p_oe_low) // R6
        else $error("Driver enable not low while driving.");

    property p_in_quiet;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        (i_mode == DDC_IN)[*3] |-> (o_dq_oe == '0 && !o_tx_ready);
    endproperty
    a_in_quiet: assert property (p_in_quiet) // R2
        else $error("Input mode still drives the pins.");

    property p_ready_phase;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        o_tx_ready |-> (o_mem_clk ##1 !o_mem_clk);
    endproperty
    a_ready_phase: assert property (p_ready_phase) // R16
        else $error("Transmit word taken in the wrong phase.");

    property p_ovf_set;
        @(posedge i_sys_clk) disable iff (!i_rstn || i_sclr)
        (cap_push && !o_cap_ready) |=> o_rx_overflow;
    endproperty
    a_ovf_set: assert property (p_ovf_set) // R11
        else $error("Dropped capture word did not flag overflow.");

    property p_grp_mask;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_rx_valid |-> ((o_rx_data & ~{lane_mask, lane_mask}) == '0);
    endproperty
    a_grp_mask: assert property (p_grp_mask) // R9
        else $error("Lane outside the strobe group captured.");

endmodule

/* dv/ddc_mem_model.sv */
`timescale 1ns/1ps
module ddc_mem_model
    import ddc_pkg::*;
(
    output logic            o_dqs,
    output logic [DQ_W-1:0] o_dq
);
    ////////////////////////////////////////////////////////////////////////
    // Strobe rests low between bursts; a released data bus shows the
    // inverse of its last bit so a stale value can never pass as fresh.
    initial begin
        o_dqs = 1'b0;
        o_dq  = '0;
    end

    task automatic send(input logic [DQ_W-1:0] a, input logic [DQ_W-1:0] b,
                        input int gap);
        o_dq = a;
        #31.25 o_dqs = 1'b1;
        #31.25 o_dq = b;
        #31.25 o_dqs = 1'b0;
        #31.25 o_dq = ~b;
        #(gap);
    endtask
endmodule

/* dv/ddc_dq_cell_tb.sv */
`timescale 1ns/1ps
module ddc_dq_cell_tb
    import ddc_pkg::*;
;
    logic                 i_sys_clk = 1'b0, i_rstn = 1'b1, i_sclr = 1'b0;
    ddc_mode_t            i_mode = DDC_IN;
    ddc_grp_t             i_grp_w = DDC_X4;
    logic                 i_align_rise = 1'b0, i_inv_dqs = 1'b0;
    logic                 i_inv_dq = 1'b0, i_inv_tx = 1'b0, i_inv_oe = 1'b0;
    logic                 i_tx_valid = 1'b0, i_tx_oe = 1'b0, i_ovf_clr = 1'b0;
    logic                 i_rx_ready = 1'b1, ref_clk = 1'b0, jitter = 1'b0;
    logic                 i_top_use_pll = 1'b0, i_bot_use_pll = 1'b1;
    logic [DQS_PAIRS-1:0] i_top_dqs_en = '0, i_bot_dqs_en = '0;
    logic [DQ_W-1:0]      i_tx_a = '0, i_tx_b = '0, i_dq, o_dq, o_dq_oe, r;
    logic                 i_dqs, o_mem_clk, o_tx_ready, o_rx_valid;
    logic                 o_cap_ready, o_rx_overflow, o_top_locked;
    logic                 o_bot_locked;
    logic [WORD_W-1:0]    o_rx_data, rx_exp;
    logic [LANE_BITS-1:0] o_top_dqs_code, o_bot_dqs_code;
    logic [WORD_W-1:0]    rxq[$];
    logic [DQ_W-1:0]      prev_oe = '0, last_b = '0;
    logic [31:0]          seed = 32'h0000_8d67;
    int                   err_count = 0, checked = 0;
    int                   widths[4] = '{4, 9, 18, 36};
    wire  [41:0]          rst_view = {o_cap_ready, o_rx_valid, o_tx_ready,
                                      o_mem_clk, o_rx_overflow, o_top_locked,
                                      o_dq_oe};

    always #2 i_sys_clk = ~i_sys_clk;
    always #62.5 ref_clk = ~ref_clk;

    ddc_dq_cell uut (
        .i_sys_clk, .i_rstn, .i_sclr, .i_mode, .i_grp_w, .i_align_rise,
        .i_inv_dq, .i_inv_dqs, .i_inv_tx, .i_inv_oe, .i_dqs, .i_dq, .o_dq,
        .o_dq_oe, .o_mem_clk, .i_tx_valid, .i_tx_a, .i_tx_b, .i_tx_oe,
        .o_tx_ready, .o_rx_valid, .o_rx_data, .i_rx_ready, .o_cap_ready,
        .o_rx_overflow, .i_ovf_clr, .i_top_ref_pin(ref_clk),
        .i_top_pll5_clk(ref_clk), .i_top_use_pll, .i_top_dqs_en,
        .o_top_dqs_code, .o_top_locked, .i_bot_ref_pin(ref_clk),
        .i_bot_pll6_clk(ref_clk), .i_bot_use_pll, .i_bot_dqs_en,
        .o_bot_dqs_code, .o_bot_locked
    );
    ddc_mem_model mem (.o_dqs(i_dqs), .o_dq(i_dq));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [DQ_W-1:0] rnd36();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {seed[3:0], seed};
    endfunction

    task automatic cmp(input string name, input logic [WORD_W+7:0] exp,
                       input logic [WORD_W+7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic rx_send(input int gap, input bit keep);
        logic [DQ_W-1:0]   a, b, m;
        logic [WORD_W-1:0] w;
        a = rnd36();
        b = rnd36();
        m = {DQ_W{1'b1}} >> (DQ_W - widths[i_grp_w]);
        w = (i_align_rise ^ i_inv_dqs) ? {a, last_b} : {b, a};
        if (i_inv_dqs) w = {w[DQ_W-1:0], w[WORD_W-1:DQ_W]};
        last_b = b;
        if (keep) rxq.push_back((w ^ {WORD_W{i_inv_dq}}) & {m, m});
        mem.send(a, b, gap);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (rxq.size() > 0 && n < 2000) begin
            n++;
            @(posedge i_sys_clk);
        end
        cmp("drain", '0, rxq.size());
    endtask

    task automatic tx_word(input logic inv);
        logic [DQ_W-1:0] a, b;
        int n;
        a = rnd36();
        b = rnd36();
        n = 0;
        @(posedge i_sys_clk);
        i_inv_tx <= inv;
        i_tx_valid <= 1'b1;
        i_tx_a <= a;
        i_tx_b <= b;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_tx_ready !== 1'b1 && n < 20);
        i_tx_valid <= 1'b0;
        @(posedge i_sys_clk);
        #1 cmp("tx_hi", {1'b1, a ^ {DQ_W{inv}}}, {o_mem_clk, o_dq});
        @(posedge i_sys_clk);
        #1 cmp("tx_lo", {1'b0, b ^ {DQ_W{inv}}}, {o_mem_clk, o_dq});
    endtask

    task automatic lane_check(input logic en, input logic [CODE_W-1:0] c);
        cmp("lane_code", {en, en}, {c == 8'h07 || c == 8'h08, c != 8'h00});
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_sys_clk) begin
        r = rnd36();
        if (jitter) i_rx_ready <= r[0];
        if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
            rx_exp = rxq.size() > 0 ? rxq.pop_front() : 'x;
            cmp("rx_data", rx_exp, o_rx_data);
        end
    end

    always @(posedge i_sys_clk) begin
        #1;
        if (o_dq_oe !== prev_oe) cmp("oe_edge", 1'b0, o_mem_clk);
        prev_oe = o_dq_oe;
    end

    // The span covers every burst with ample margin at the strobe rate.
    initial begin
        #200000;
        err_count++;
        $display("Error watchdog expected finish seen timeout");
        give_verdict();
    end

    initial begin
        r = rnd36();
        i_top_dqs_en = r[17:0];
        i_bot_dqs_en = r[35:18];
        // A real falling reset edge clears the strobe-side flops.
        #1 i_rstn = 1'b0;
        repeat (16) @(posedge i_sys_clk);
        cmp("reset", {1'b1, 41'h0}, rst_view);
        i_rstn <= 1'b1;
        jitter = 1'b1;
        for (int g = 0; g < 8; g++) begin
            @(posedge i_sys_clk);
            i_grp_w <= ddc_grp_t'(g[1:0]);
            i_inv_dq <= g[2];
            i_align_rise <= g[1];
            i_inv_dqs <= g[0];
            repeat (8) @(posedge i_sys_clk);
            for (int k = 0; k < 4; k++) rx_send(k * 40, 1'b1);
            drain();
        end
        jitter = 1'b0;
        @(posedge i_sys_clk);
        i_rx_ready <= 1'b0;
        for (int k = 0; k < 20; k++) rx_send(0, k < 17);
        repeat (8) @(posedge i_sys_clk);
        cmp("ovf", 2'b10, {o_rx_overflow, o_cap_ready});
        i_ovf_clr <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_ovf_clr <= 1'b0;
        i_rx_ready <= 1'b1;
        #1 cmp("ovf_clr", 1'b0, o_rx_overflow);
        drain();
        @(posedge i_sys_clk);
        i_mode <= DDC_OUT;
        rx_send(0, 1'b0);
        for (int k = 0; k < 6; k++) tx_word(k[0]);
        cmp("oe_out", {DQ_W{1'b1}}, o_dq_oe);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_sys_clk);
            i_mode <= DDC_BIDIR;
            i_tx_oe <= k[0];
            i_inv_oe <= k[1];
            fork
                rx_send(0, 1'b1);
                tx_word(1'b0);
            join
            #1 cmp("oe_bidir", {DQ_W{k[0] ^ k[1]}}, o_dq_oe);
        end
        drain();
        @(posedge i_sys_clk);
        i_sclr <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1 cmp("sclr", '0, {o_mem_clk, o_dq_oe, o_dq});
        @(posedge i_sys_clk);
        i_sclr <= 1'b0;
        i_mode <= DDC_IN;
        repeat (6) @(posedge i_sys_clk);
        #1 cmp("in_idle", '0, {o_tx_ready, o_dq_oe});
        for (int i = 0; i < DQS_PAIRS; i++) begin
            lane_check(i_top_dqs_en[i], o_top_dqs_code[CODE_W*i +: CODE_W]);
            lane_check(i_bot_dqs_en[i], o_bot_dqs_code[CODE_W*i +: CODE_W]);
        end
        cmp("locked", 2'b11, {o_top_locked, o_bot_locked});
        give_verdict();
    end
endmodule
